//--- logic/fra_pkg.sv
`default_nettype none
package fra_pkg;

  // register byte addresses, one aligned 32-bit word each
  localparam logic [7:0] FRA_ADR_CMD    = 8'h00;
  localparam logic [7:0] FRA_ADR_WORK   = 8'h04;
  localparam logic [7:0] FRA_ADR_STATUS = 8'h08;
  localparam logic [7:0] FRA_ADR_FPTR   = 8'h0C;
  localparam logic [7:0] FRA_ADR_FDATA  = 8'h10;

  // command word layout
  localparam int FRA_CMD_ADDR_LSB = 0;
  localparam int FRA_CMD_ADDR_W   = 7;
  localparam int FRA_CMD_DEST_BIT = 7;
  localparam int FRA_CMD_OP_LSB   = 8;
  localparam int FRA_CMD_OP_W     = 3;

  // status word layout
  localparam int FRA_STAT_C_BIT = 0;
  localparam int FRA_STAT_Z_BIT = 1;

  // sizes of the datapath
  localparam int FRA_DATA_W  = 8;
  localparam int FRA_FILE_N  = 128;

  // reset values
  localparam logic [7:0] FRA_WORK_RST = 8'h00;
  localparam logic       FRA_C_RST    = 1'b0;
  localparam logic       FRA_Z_RST    = 1'b0;
  localparam logic [7:0] FRA_FILE_RST = 8'h00;

  // operation codes, in command-field order
  typedef enum logic [2:0] {
    increment_file_op,
    or_work_with_file_op,
    shift_left_logical_op,
    shift_right_logical_op,
    move_file_op
  } fra_op_t;

  // one datapath answer
  typedef struct packed {
    logic [7:0] data;
    logic       c;
    logic       upd_c;
    logic       z;
  } fra_alu_res_t;

  // whole state of the block
  typedef struct packed {
    logic [FRA_FILE_N-1:0][7:0] file;
    logic [7:0]                 w;
    logic                       c;
    logic                       z;
    logic [6:0]                 cmd_addr;
    logic                       cmd_dest;
    fra_op_t                    cmd_op;
    logic [6:0]                 fptr;
    logic                       ack;
    logic [31:0]                rdat;
  } fra_state_t;

endpackage : fra_pkg
`default_nettype wire

//--- logic/fra_core.sv
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RL1] address 0..127 plus selector; selector zero writes working reg only
// [RL2] selector one writes result back into the addressed file register
// [RL3] increment adds one to file byte, updates zero flag only
// [RL4] or combines working and file bytes, updates zero flag only
// [RL5] left shift: bit 7 to carry, bits 6..0 up one; carry and zero
// [RL6] left shift always fills result bit 0 with zero
// [RL7] right shift: bit 0 to carry, bits 7..1 down one; carry and zero
// [RL8] right shift always clears result bit 7
// [RL9] move copies file byte unchanged to destination, zero flag only
// [RL10] move back to the file still updates zero, acting as a test
// [RL11] zero flag mirrors result equal zero; carry keeps its value except on the two shifts
// [RL12] read, compute, write and flag update finish in one cycle
module fra_core
  import fra_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        nrst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out
);

  fra_state_t   st;
  fra_state_t   next_st;
  fra_alu_res_t res;
  logic         req;
  logic         exec;
  logic [2:0]   op_bits;
  fra_op_t      op;
  logic [6:0]   op_addr;
  logic         op_dest;
  logic [7:0]   src_f;
  logic [7:0]   dest_now;

  // datapath for the five file operations
  function automatic fra_alu_res_t fra_alu(
    input fra_op_t    fop,
    input logic [7:0] f,
    input logic [7:0] w
  );
    fra_alu_res_t r;
    // carry defaults to no update, so only the shifts can move it
    r.data  = f;
    r.c     = 1'b0;
    r.upd_c = 1'b0;
    case (fop)
      increment_file_op: begin
        r.data = f + 8'h01;                          // [RL3]
      end
      or_work_with_file_op: begin
        r.data = w | f;                              // [RL4]
      end
      shift_left_logical_op: begin
        r.data  = {f[6:0], 1'b0};                    // [RL5] [RL6]
        r.c     = f[7];                              // [RL5]
        r.upd_c = 1'b1;
      end
      shift_right_logical_op: begin
        r.data  = {1'b0, f[7:1]};                    // [RL7] [RL8]
        r.c     = f[0];                              // [RL7]
        r.upd_c = 1'b1;
      end
      move_file_op: begin
        r.data = f;                                  // [RL9]
      end
      default: begin
        r.data = f;
      end
    endcase
    r.z = (r.data == 8'h00);                         // [RL11] [RL10]
    return r;
  endfunction : fra_alu

  // command field decode from the bus write data
  assign op_bits = wb_dat_in[FRA_CMD_OP_LSB +: FRA_CMD_OP_W];
  assign op      = fra_op_t'(op_bits);
  assign op_addr = wb_dat_in[FRA_CMD_ADDR_LSB +: FRA_CMD_ADDR_W];
  assign op_dest = wb_dat_in[FRA_CMD_DEST_BIT];
  assign src_f   = st.file[op_addr];
  assign res     = fra_alu(op, src_f, st.w);

  // one new request per ack; ack drops the cycle after it is given
  assign req  = wb_cyc_in & wb_stb_in & ~st.ack;
  // undefined opcodes are ignored so a stray write cannot corrupt state
  assign exec = req & wb_we_in & (wb_adr_in == FRA_ADR_CMD)
              & wb_sel_in[0] & wb_sel_in[1]
              & (op_bits <= 3'(move_file_op));

  // byte at the last command's destination, for checking only
  assign dest_now = st.cmd_dest ? st.file[st.cmd_addr] : st.w;

  // next-state logic: bus slave plus operation execution
  always_comb begin
    next_st     = st;
    next_st.ack = 1'b0;
    if (req) begin
      next_st.ack  = 1'b1;
      next_st.rdat = 32'h0000_0000;
      case (wb_adr_in)
        FRA_ADR_CMD: begin
          next_st.rdat = {21'h00_0000, 3'(st.cmd_op), st.cmd_dest,
                          st.cmd_addr};
          // a refused command still acks, so software never waits
          if (exec) begin
            next_st.cmd_addr = op_addr;
            next_st.cmd_dest = op_dest;
            next_st.cmd_op   = op;
            if (op_dest) begin
              next_st.file[op_addr] = res.data;      // [RL2] [RL12]
            end else begin
              next_st.w = res.data;                  // [RL1] [RL12]
            end
            next_st.z = res.z;                       // [RL11] [RL10]
            if (res.upd_c) begin
              next_st.c = res.c;                     // [RL5] [RL7]
            end
          end
        end
        FRA_ADR_WORK: begin
          next_st.rdat = {24'h00_0000, st.w};
          if (wb_we_in && wb_sel_in[0]) begin
            next_st.w = wb_dat_in[7:0];
          end
        end
        FRA_ADR_STATUS: begin
          next_st.rdat[FRA_STAT_C_BIT] = st.c;
          next_st.rdat[FRA_STAT_Z_BIT] = st.z;
          if (wb_we_in && wb_sel_in[0]) begin
            next_st.c = wb_dat_in[FRA_STAT_C_BIT];
            next_st.z = wb_dat_in[FRA_STAT_Z_BIT];
          end
        end
        FRA_ADR_FPTR: begin
          next_st.rdat = {25'h000_0000, st.fptr};
          if (wb_we_in && wb_sel_in[0]) begin
            next_st.fptr = wb_dat_in[6:0];
          end
        end
        FRA_ADR_FDATA: begin
          next_st.rdat = {24'h00_0000, st.file[st.fptr]};
          if (wb_we_in && wb_sel_in[0]) begin
            next_st.file[st.fptr] = wb_dat_in[7:0];
          end
        end
        default: begin
          next_st.rdat = 32'h0000_0000;              // unmapped reads zero
        end
      endcase
    end
  end

  // state register; reset takes constants only
  // the wide file reset costs area but keeps every byte known
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st          <= '0;
      st.file     <= {FRA_FILE_N{FRA_FILE_RST}};
      st.w        <= FRA_WORK_RST;
      st.c        <= FRA_C_RST;
      st.z        <= FRA_Z_RST;
      st.cmd_op   <= increment_file_op;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign wb_dat_out = st.rdat;
  assign wb_ack_out = st.ack;

  // checks on the executed operation, one cycle after acceptance
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);

  dest_zero_a: assert property (                     // [RL1]
    exec && !op_dest |=> st.w == $past(res.data)
      && st.file[$past(op_addr)] == $past(src_f))
    else $error("selector zero did not go to working register");

  dest_file_a: assert property (                     // [RL2]
    exec && op_dest |=> st.file[$past(op_addr)] == $past(res.data)
      && st.w == $past(st.w))
    else $error("selector one did not go to file register");

  inc_value_a: assert property (                     // [RL3]
    exec && op == increment_file_op
      |=> dest_now == 8'($past(src_f) + 8'h01) && st.c == $past(st.c))
    else $error("increment result or carry wrong");

  or_value_a: assert property (                      // [RL4]
    exec && op == or_work_with_file_op
      |=> dest_now == ($past(src_f) | $past(st.w)) && $stable(st.c))
    else $error("or result or carry wrong");

  shl_value_a: assert property (                     // [RL5]
    exec && op == shift_left_logical_op
      |=> dest_now[7:1] == $past(src_f[6:0]) && st.c == $past(src_f[7]))
    else $error("left shift result or carry wrong");

  shl_fill_a: assert property (                      // [RL6]
    exec && op == shift_left_logical_op |=> dest_now[0] == 1'b0)
    else $error("left shift did not fill zero");

  shr_value_a: assert property (                     // [RL7]
    exec && op == shift_right_logical_op
      |=> dest_now[6:0] == $past(src_f[7:1]) && st.c == $past(src_f[0]))
    else $error("right shift result or carry wrong");

  shr_fill_a: assert property (                      // [RL8]
    exec && op == shift_right_logical_op |=> dest_now[7] == 1'b0)
    else $error("right shift did not clear top bit");

  move_copy_a: assert property (                     // [RL9]
    exec && op == move_file_op
      |=> dest_now == $past(src_f) && st.c == $past(st.c))
    else $error("move changed byte or carry");

  move_test_a: assert property (                     // [RL10]
    exec && op == move_file_op && op_dest
      |=> st.z == ($past(src_f) == 8'h00))
    else $error("move test did not update zero");

  zero_flag_a: assert property (                     // [RL11]
    exec |=> st.z == (dest_now == 8'h00))
    else $error("zero flag does not match result");

  one_cycle_a: assert property (                     // [RL12]
    exec |=> wb_ack_out ##1 !wb_ack_out)
    else $error("operation not finished in one cycle");

  // bus side: one answer per request and never unprompted
  ack_pulse_a: assert property (                     // [RL12]
    wb_ack_out |=> !wb_ack_out)
    else $error("ack stood longer than one cycle");

  ack_cause_a: assert property (                     // [RL12]
    !(wb_cyc_in && wb_stb_in && !wb_ack_out) |=> !wb_ack_out)
    else $error("ack given with no request");

  // the destination not chosen keeps its byte
  file_keep_a: assert property (                     // [RL1]
    exec && !op_dest |=> st.file == $past(st.file))
    else $error("file array changed with selector zero");

  work_keep_a: assert property (                     // [RL2]
    !(exec && !op_dest)
      && !(req && wb_we_in && wb_adr_in == FRA_ADR_WORK)
      |=> $stable(st.w))
    else $error("working register changed unasked");

  // corner bytes where a slip in width or fill shows at once
  inc_wrap_a: assert property (                      // [RL3]
    exec && op == increment_file_op && src_f == 8'hFF
      |=> dest_now == 8'h00 && st.z)
    else $error("increment did not wrap to zero");

  or_zero_a: assert property (                       // [RL4]
    exec && op == or_work_with_file_op && src_f == 8'h00
      && st.w == 8'h00 |=> dest_now == 8'h00 && st.z)
    else $error("or of zero bytes did not set zero");

  shl_out_a: assert property (                       // [RL5]
    exec && op == shift_left_logical_op && src_f == 8'h80
      |=> dest_now == 8'h00 && st.z && st.c)
    else $error("left shift of top bit wrong");

  shr_out_a: assert property (                       // [RL7]
    exec && op == shift_right_logical_op && src_f == 8'h01
      |=> dest_now == 8'h00 && st.z && st.c)
    else $error("right shift of low bit wrong");

  test_keep_a: assert property (                     // [RL10]
    exec && op == move_file_op && op_dest
      |=> st.file[$past(op_addr)] == $past(src_f) && $stable(st.w))
    else $error("move test changed the file byte");

  // carry belongs to the shifts alone; flags move only when asked
  carry_keep_a: assert property (                    // [RL11]
    exec && op != shift_left_logical_op
      && op != shift_right_logical_op |=> $stable(st.c))
    else $error("carry changed by a non-shift operation");

  flag_keep_a: assert property (                     // [RL11]
    !exec && !(req && wb_we_in && wb_adr_in == FRA_ADR_STATUS)
      |=> $stable(st.c) && $stable(st.z))
    else $error("flag changed with no operation");

  cov_inc_file: cover property (
    exec && op == increment_file_op && op_dest);
  cov_shl_carry: cover property (
    exec && op == shift_left_logical_op && src_f[7]);
  cov_shr_zero: cover property (
    exec && op == shift_right_logical_op && src_f == 8'h01);
  cov_move_test: cover property (
    exec && op == move_file_op && op_dest && src_f == 8'h00);
  cov_bad_op: cover property (
    req && wb_we_in && wb_adr_in == FRA_ADR_CMD && !exec);

endmodule : fra_core
`default_nettype wire

//--- test/fra_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fra_core_tb
  import fra_pkg::*;
;

  logic        clock_in  = 1'b0;
  logic        nrst_in   = 1'b0;
  logic        cyc       = 1'b0;
  logic        stb       = 1'b0;
  logic        we        = 1'b0;
  logic [7:0]  adr       = 8'h00;
  logic [3:0]  sel       = 4'h0;
  logic [31:0] wdat      = 32'h0;
  logic [3:0]  lanes     = 4'hF;
  logic [31:0] wb_dat_out;
  logic        wb_ack_out;
  int          n_fail    = 0;
  int          comparisons = 0;

  fra_core fra_core_i (
    .clock_in   (clock_in),
    .nrst_in    (nrst_in),
    .wb_cyc_in  (cyc),
    .wb_stb_in  (stb),
    .wb_we_in   (we),
    .wb_adr_in  (adr),
    .wb_sel_in  (sel),
    .wb_dat_in  (wdat),
    .wb_dat_out (wb_dat_out),
    .wb_ack_out (wb_ack_out)
  );

  // 250 MHz core clock
  always #2 clock_in = ~clock_in;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one classic cycle; waits for ack rather than assuming a latency
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= lanes;
    do begin
      @(posedge clock_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    if (n >= 20) n_fail++;
    q = wb_dat_out;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock_in);
  endtask : bus

  // reference datapath: returns {carry, result}
  function automatic logic [8:0] calc(input int op, input logic [7:0] f,
                                      input logic [7:0] w, input logic c);
    case (op)
      0: return {c, f + 8'h01};
      1: return {c, w | f};
      2: return {f[7], f[6:0], 1'b0};
      3: return {f[0], 1'b0, f[7:1]};
      default: return {c, f};
    endcase
  endfunction : calc

  // watchdog sized well above the ~60 op sequences
  initial begin
    repeat (20000) @(posedge clock_in);
    n_fail++;
    finish_test();
  end

  // main sequence
  initial begin
    logic [31:0] q, last;
    logic [7:0]  f, w, r;
    logic [6:0]  a;
    logic [1:0]  st;
    logic [8:0]  res;
    logic        d, c, z;
    int          op;
    logic [7:0]  corner [4];
    corner = '{8'hFF, 8'h80, 8'h01, 8'h00};
    void'($urandom(77));
    repeat (5) @(posedge clock_in);
    nrst_in <= 1'b1;
    @(posedge clock_in);
    bus(1'b0, FRA_ADR_WORK, 32'h0, q);
    check("work after reset", q, 32'h0);
    bus(1'b0, FRA_ADR_STATUS, 32'h0, q);
    check("status after reset", q, 32'h0);
    // unmapped place acks, reads zero
    bus(1'b1, 8'h14, 32'hFFFF_FFFF, q);
    bus(1'b0, 8'h14, 32'h0, q);
    check("unmapped", q, 32'h0);
    last = 32'h0;
    for (int i = 0; i < 60; i++) begin
      op = (i < 16) ? i % 8 : $urandom_range(0, 7);
      d  = (i < 16) ? (i >= 8) : 1'($urandom_range(0, 1));
      a  = (i % 5 == 0) ? 7'h7F : 7'($urandom_range(0, 127));
      f  = (i % 2 == 0) ? corner[(i / 2) % 4] : 8'($urandom);
      w  = (i % 6 == 1) ? 8'h00 : 8'($urandom);
      st = 2'($urandom_range(0, 3));
      bus(1'b1, FRA_ADR_FPTR, {25'h0, a}, q);
      bus(1'b0, FRA_ADR_FPTR, 32'h0, q);
      check("pointer", q, {25'h0, a});
      bus(1'b1, FRA_ADR_FDATA, {24'h0, f}, q);
      bus(1'b1, FRA_ADR_WORK, {24'h0, w}, q);
      bus(1'b1, FRA_ADR_STATUS, {30'h0, st}, q);
      bus(1'b1, FRA_ADR_CMD, {21'h0, 3'(op), d, a}, q);
      c = st[0];
      z = st[1];
      // codes 5..7 must leave every register alone
      if (op < 5) begin
        res = calc(op, f, w, c);
        r   = res[7:0];
        z   = (r == 8'h00);
        if (op == 2 || op == 3) c = res[8];
        if (d) f = r;
        else w = r;
        last = {21'h0, 3'(op), d, a};
      end
      bus(1'b0, FRA_ADR_WORK, 32'h0, q);
      check("work", q, {24'h0, w});
      bus(1'b0, FRA_ADR_FDATA, 32'h0, q);
      check("file", q, {24'h0, f});
      bus(1'b0, FRA_ADR_STATUS, 32'h0, q);
      check("status", q, {30'h0, z, c});
      bus(1'b0, FRA_ADR_CMD, 32'h0, q);
      check("last command", q, last);
    end
    // a command without both low byte lanes acks and does nothing
    lanes = 4'h1;
    bus(1'b1, FRA_ADR_CMD, {21'h0, 3'h0, 1'b0, a}, q);
    lanes = 4'hF;
    bus(1'b0, FRA_ADR_CMD, 32'h0, q);
    check("half lane command", q, last);
    bus(1'b0, FRA_ADR_WORK, 32'h0, q);
    check("half lane work", q, {24'h0, w});
    // a reset in mid-run clears the file array and flags again
    nrst_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'b1;
    @(posedge clock_in);
    bus(1'b0, FRA_ADR_FDATA, 32'h0, q);
    check("file after reset", q, 32'h0);
    bus(1'b0, FRA_ADR_STATUS, 32'h0, q);
    check("flags after reset", q, 32'h0);
    finish_test();
  end

endmodule : fra_core_tb
`default_nettype wire
